// >>> logic/pcs_pkg.sv
// Shared constants, register layouts and types of the PC Card socket block.
package pcs_pkg;

  // ********************************************************************
  // Register map and widths
  // ********************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0C;
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;
  localparam logic [1:0] CLKRUN_ON = 2'h3;

  // ********************************************************************
  // Modes, card kinds and state types
  // ********************************************************************
  typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_CARDBUS} pcs_mode_t;
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_16_5V = 2'h1;
  localparam logic [1:0] KIND_16_3V = 2'h2;
  localparam logic [1:0] KIND_CARDBUS = 2'h3;
  typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD}
    pcs_cyc_t;

  // Control register, bit 0 at the right.
  typedef struct packed {
    logic pme_enable;
    logic clock_keep;
    logic [1:0] clkrun_enable;
    logic ring_select;
    logic led_select;
    logic reset_card;
    logic iface_enable;
    logic card_power;
    logic eight_bit;
    logic spare;
    logic [1:0] mode;
  } pcs_ctrl_t;

  // Command register: one 16-bit card cycle.
  typedef struct packed {
    logic word;
    logic is_io;
    logic write;
    logic a0;
    logic [15:0] data;
  } pcs_cmd_t;
  localparam int CMD_W = 20;

  // Status register, bit 0 at the right.
  typedef struct packed {
    logic card_request;
    logic clock_stop_ok;
    logic cardbus_irq;
    logic cardbus_change;
    logic status_change;
    logic battery_dead;
    logic battery_warn;
    logic write_protect;
    logic io_wide;
    logic ready;
    logic io_irq;
    logic card_present;
    logic [1:0] card_kind;
    logic busy;
  } pcs_status_t;
  localparam int STATUS_W = 15;
  localparam int STATUS_CHANGE_BIT = 10;

  // Values the CardBus engine puts on the reused 16-bit pins.
  typedef struct packed {
    logic cad13;
    logic cad15;
    logic cad11;
    logic cgnt_n;
    logic cad10;
    logic ccbe0_n;
  } pcs_cb_pins_t;

  // ********************************************************************
  // Synchroniser lanes and timing
  // ********************************************************************
  localparam int SYNC_W = 10;
  localparam int SY_READY = 0;
  localparam int SY_WAIT = 1;
  localparam int SY_CD1 = 2;
  localparam int SY_CD2 = 3;
  localparam int SY_VS1 = 4;
  localparam int SY_VS2 = 5;
  localparam int SY_BWARN = 6;
  localparam int SY_BDEAD = 7;
  localparam int SY_WP = 8;
  localparam int SY_INACK = 9;
  localparam int CLK_NS = 8;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

endpackage

// >>> logic/pcs_socket.sv
// Socket-side signalling of a single-slot PC Card / CardBus controller.
`timescale 1ns/1ps
// How it works
// - I/O read strobe low only during an I/O read cycle.
// - I/O write strobe low only during an I/O write cycle.
// - Memory mode reads the shared pin as write-protect status.
// - I/O mode uses the shared pin to size the transfer as 16-bit.
// - CardBus mode uses the shared pin as clock run when enabled.
// - Memory mode reads ready_or_irq as ready high, busy low.
// - I/O mode reads ready_or_irq as card interrupt request.
// - CardBus interrupt is active low and sensed by level.
// - Card wait extends the active strobe until released.
// - Both card_detect inputs low mean a card is seated.
// - Voltage sense and detect pins give card type and voltage.
// - card_enable_odd low selects odd bytes.
// - card_enable_even low selects even bytes.
// - Eight-bit cards use only card_enable_even, with A0 picking the byte, except an I/O word cycle the shared pin sizes as 16-bit.
// - Card reset is high to reset (low in CardBus mode), driven only when seated, powered, enabled.
// - battery_warn is warning in memory mode, speaker or LED in I/O mode.
// - battery_dead is dead status, or status change or ring wake.
// - CardBus status change can raise the power-management event.
// - input_ack ignored for 16-bit cards, card request in CardBus mode.
// - CardBus mode routes strobe and enable pins to CardBus lines.
// - Memory read enable low during a memory read cycle.
// - Memory write enable low during a memory write cycle.
module pcs_socket #(
  parameter int SETUP_COUNT = pcs_pkg::SETUP_CYC,
  parameter int STROBE_COUNT = pcs_pkg::STROBE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pcs_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic mem_read_enable_n,
  output logic mem_write_enable_n,
  output logic card_enable_even_n,
  output logic card_enable_odd_n,
  output logic card_a0,
  input wire logic [15:0] card_data_in,
  output logic [15:0] card_data_out,
  output logic card_data_oe,
  input wire logic protect_or_width,
  output logic clkrun_out_n,
  output logic clkrun_oe,
  output logic cardbus_clk_run,
  input wire logic ready_or_irq,
  input wire logic cycle_wait_n,
  input wire logic input_ack_n,
  input wire logic [1:0] card_detect_n,
  input wire logic [1:0] voltage_sense,
  input wire logic battery_warn,
  input wire logic battery_dead,
  output logic card_reset_out,
  output logic card_reset_oe,
  input wire pcs_pkg::pcs_cb_pins_t cb_pins,
  output logic card_irq,
  output logic card_speaker,
  output logic activity_led,
  output logic ring_wake,
  output logic pme_n,
  output logic card_present
);
  import pcs_pkg::*;

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************

  // Card kind from the detect and voltage sense pins.
  function automatic logic [1:0] card_kind_of(input logic [1:0] cd_n,
                                              input logic [1:0] vs);
    logic [1:0] kind;
    kind = KIND_NONE;
    if (cd_n == 2'h0)
    begin
      kind = vs[0] ? KIND_16_5V : KIND_16_3V;
    end
    else if (cd_n != 2'h3 && vs != 2'h3)
    begin
      kind = KIND_CARDBUS;
    end
    return kind;
  endfunction

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_prev;
  pcs_ctrl_t ctrl;
  pcs_cmd_t cmd;
  pcs_cyc_t state;
  pcs_status_t status;
  logic [CNT_W-1:0] cnt;
  logic [15:0] read_data;
  logic status_change;
  logic wide;
  logic wide_now;
  logic bus_write;
  logic bus_setup;
  logic addr_ok;
  logic cardbus;
  logic io_mode;
  logic mem_mode;
  logic clkrun_active;
  logic [1:0] kind;
  logic change_edge;

  // ********************************************************************
  // Input synchroniser
  // ********************************************************************

  // Asynchronous inputs in one vector.
  assign async_in = {input_ack_n, protect_or_width, battery_dead,
                     battery_warn, voltage_sense[1], voltage_sense[0],
                     card_detect_n[1], card_detect_n[0], cycle_wait_n,
                     ready_or_irq};

  // Two flip-flops per input feed the logic; a third stage delays the second for edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= '1;
      sync_b <= '1;
      sync_prev <= '1;
    end
    else
    begin
      sync_a <= async_in;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // Common mode terms.
  assign cardbus = (ctrl.mode == 2'(MODE_CARDBUS));
  assign io_mode = (ctrl.mode == 2'(MODE_IO));
  assign mem_mode = !cardbus && !io_mode;
  assign kind = card_kind_of(sync_b[SY_CD2:SY_CD1],
                             sync_b[SY_VS2:SY_VS1]);
  assign clkrun_active = cardbus && (ctrl.clkrun_enable == CLKRUN_ON);
  assign change_edge = sync_prev[SY_BDEAD] && !sync_b[SY_BDEAD];
  assign wide_now = (state != CYC_SETUP) ? wide : cmd.word &&
                    (cmd.is_io ? !sync_b[SY_WP] : !ctrl.eight_bit);

  // ********************************************************************
  // APB slave
  // ********************************************************************

  // Zero-wait slave; unmapped addresses answer with an error.
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_RDATA);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Control register; mode moves only while idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (bus_write && paddr == ADDR_CTRL)
    begin
      ctrl <= pwdata[CTRL_W-1:0];
      if (state != CYC_IDLE || pwdata[1:0] == 2'h3)
      begin
        ctrl.mode <= ctrl.mode;
      end
    end
  end

  // Read data is registered during the setup phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (bus_setup)
    begin
      unique case (paddr)
        ADDR_CTRL: prdata <= {{(32-CTRL_W){1'b0}}, ctrl};
        ADDR_CMD: prdata <= {{(32-CMD_W){1'b0}}, cmd};
        ADDR_STATUS: prdata <= {{(32-STATUS_W){1'b0}}, status};
        ADDR_RDATA: prdata <= {16'h0000, read_data};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Status word seen by software.
  always_comb
  begin
    status = '0;
    status.busy = (state != CYC_IDLE);
    status.card_kind = kind;
    status.card_present = (kind != KIND_NONE);
    status.io_irq = io_mode && !sync_b[SY_READY];
    status.ready = mem_mode && sync_b[SY_READY];
    status.io_wide = io_mode && !sync_b[SY_WP];
    status.write_protect = mem_mode && sync_b[SY_WP];
    status.battery_warn = mem_mode && sync_b[SY_BWARN];
    status.battery_dead = mem_mode && sync_b[SY_BDEAD];
    status.status_change = status_change;
    status.cardbus_change = cardbus && sync_b[SY_BDEAD];
    status.cardbus_irq = cardbus && !sync_b[SY_READY];
    status.clock_stop_ok = clkrun_active && sync_b[SY_WP];
    status.card_request = cardbus && !sync_b[SY_INACK];
  end

  // Sticky status change; an event wins over a clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_change <= 1'b0;
    end
    else if (io_mode && !ctrl.ring_select && change_edge)
    begin
      status_change <= 1'b1;
    end
    else if (bus_write && paddr == ADDR_STATUS &&
             pwdata[STATUS_CHANGE_BIT])
    begin
      status_change <= 1'b0;
    end
  end

  // ********************************************************************
  // 16-bit card cycle engine
  // ********************************************************************

  // A command write starts a cycle only when idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CYC_IDLE;
      cnt <= '0;
      cmd <= '0;
      wide <= 1'b0;
    end
    else
    begin
      unique case (state)
        CYC_IDLE:
        begin
          if (bus_write && paddr == ADDR_CMD && !cardbus)
          begin
            cmd <= pwdata[CMD_W-1:0];
            cnt <= CNT_W'(SETUP_COUNT - 1);
            state <= CYC_SETUP;
          end
        end
        CYC_SETUP:
        begin
          wide <= wide_now;
          if (cnt == '0)
          begin
            cnt <= CNT_W'(STROBE_COUNT - 1);
            state <= CYC_STROBE;
          end
          else
          begin
            cnt <= cnt - 1'b1;
          end
        end
        CYC_STROBE:
        begin
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else if (sync_b[SY_WAIT])
          begin
            state <= CYC_HOLD;
          end
        end
        CYC_HOLD:
        begin
          state <= CYC_IDLE;
        end
      endcase
    end
  end

  // Read data is taken as the strobe ends.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_data <= 16'h0000;
    end
    else if (state == CYC_STROBE && cnt == '0 && sync_b[SY_WAIT] &&
             !cmd.write)
    begin
      read_data <= card_data_in;
    end
  end

  // ********************************************************************
  // Socket pin drive
  // ********************************************************************

  // Strobes, byte enables and address bit, or CardBus lines instead.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      mem_read_enable_n <= 1'b1;
      mem_write_enable_n <= 1'b1;
      card_enable_even_n <= 1'b1;
      card_enable_odd_n <= 1'b1;
      card_a0 <= 1'b0;
    end
    else if (cardbus)
    begin
      io_read_strobe_n <= cb_pins.cad13;
      io_write_strobe_n <= cb_pins.cad15;
      mem_read_enable_n <= cb_pins.cad11;
      mem_write_enable_n <= cb_pins.cgnt_n;
      card_enable_odd_n <= cb_pins.cad10;
      card_enable_even_n <= cb_pins.ccbe0_n;
      card_a0 <= 1'b0;
    end
    else
    begin
      io_read_strobe_n <= !(next_strobe() && cmd.is_io &&
                            !cmd.write);
      io_write_strobe_n <= !(next_strobe() && cmd.is_io &&
                             cmd.write);
      mem_read_enable_n <= !(next_strobe() && !cmd.is_io &&
                             !cmd.write);
      mem_write_enable_n <= !(next_strobe() && !cmd.is_io &&
                              cmd.write);
      if (next_busy())
      begin
        card_enable_even_n <= !(wide_now || ctrl.eight_bit ||
                                !cmd.a0);
        card_enable_odd_n <= !(wide_now || (!ctrl.eight_bit &&
                               cmd.a0));
        card_a0 <= wide_now ? 1'b0 : cmd.a0;
      end
      else
      begin
        card_enable_even_n <= 1'b1;
        card_enable_odd_n <= 1'b1;
      end
    end
  end

  // Strobe is active for the whole strobe state of a cycle.
  function automatic logic next_strobe();
    return (state == CYC_SETUP && cnt == '0) ||
           (state == CYC_STROBE && !(cnt == '0 && sync_b[SY_WAIT]));
  endfunction

  // Enables cover setup after its first cycle, strobe and hold.
  function automatic logic next_busy();
    return (state == CYC_SETUP) || (state == CYC_STROBE);
  endfunction

  // Write data drives the bus for a write cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_data_out <= 16'h0000;
      card_data_oe <= 1'b0;
    end
    else
    begin
      card_data_out <= cmd.data;
      card_data_oe <= !cardbus && cmd.write && next_busy();
    end
  end

  // Card reset is driven only for a seated, powered, enabled card.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_reset_out <= 1'b0;
      card_reset_oe <= 1'b0;
    end
    else
    begin
      card_reset_out <= cardbus ? !ctrl.reset_card : ctrl.reset_card;
      card_reset_oe <= (kind != KIND_NONE) && ctrl.card_power &&
                       ctrl.iface_enable;
    end
  end

  // Clock run: the block pulls the pin low to keep the clock going.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clkrun_out_n <= 1'b1;
      clkrun_oe <= 1'b0;
      cardbus_clk_run <= 1'b1;
    end
    else
    begin
      clkrun_out_n <= 1'b0;
      clkrun_oe <= clkrun_active && ctrl.clock_keep;
      cardbus_clk_run <= !clkrun_active || ctrl.clock_keep ||
                         !sync_b[SY_WP];
    end
  end

  // Card events to the host.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_irq <= 1'b0;
      card_speaker <= 1'b0;
      activity_led <= 1'b0;
      ring_wake <= 1'b0;
      pme_n <= 1'b1;
      card_present <= 1'b0;
    end
    else
    begin
      card_irq <= (io_mode || cardbus) &&
                  !sync_b[SY_READY];
      card_speaker <= io_mode && !ctrl.led_select &&
                      !sync_b[SY_BWARN];
      activity_led <= io_mode && ctrl.led_select &&
                      !sync_b[SY_BWARN];
      ring_wake <= io_mode && ctrl.ring_select &&
                   !sync_b[SY_BDEAD];
      pme_n <= !(cardbus && ctrl.pme_enable &&
                 sync_b[SY_BDEAD]);
      card_present <= (kind != KIND_NONE);
    end
  end

endmodule // pcs_socket

// >>> tb/pcs_card_model.sv
// Behavioural model of a card seated in the socket.
`timescale 1ns/1ps
module pcs_card_model (
  input wire logic pclk,
  input wire logic strobe_n,
  input wire logic seated,
  input wire logic cardbus,
  input wire logic [3:0] wait_len,
  input wire logic [15:0] rd_word,
  output logic [1:0] card_detect_n,
  output logic [1:0] voltage_sense,
  output logic cycle_wait_n,
  output logic [15:0] card_data_in
);
  logic [3:0] left;
  // Detect pins sit at pull-up level when empty.
  assign card_detect_n = !seated ? 2'h3 : cardbus ? 2'h2 : 2'h0;
  // A CardBus card grounds one sense line, a 16-bit card none.
  assign voltage_sense = cardbus ? 2'h1 : 2'h3;
  // Data shows its inverse outside a strobe.
  assign card_data_in = strobe_n ? ~rd_word : rd_word;
  // Hold each cycle off for wait_len cycles.
  always_ff @(posedge pclk)
    if (strobe_n)
      left <= wait_len;
    else if (left != 4'h0)
      left <= left - 4'h1;
  assign cycle_wait_n = strobe_n || left == 4'h0;
endmodule // pcs_card_model

// >>> tb/pcs_socket_asserts.sv
// Concurrent checks on the ports of the socket block.
`timescale 1ns/1ps
module pcs_socket_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pcs_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic mem_read_enable_n,
  input wire logic mem_write_enable_n,
  input wire logic card_enable_even_n,
  input wire logic card_enable_odd_n,
  input wire logic card_data_oe,
  input wire logic cycle_wait_n,
  input wire logic ready_or_irq,
  input wire logic [1:0] card_detect_n,
  input wire logic card_present,
  input wire logic card_reset_oe,
  input wire logic card_irq,
  input wire pcs_pkg::pcs_cb_pins_t cb_pins
);
  import pcs_pkg::*;
  logic [1:0] mode;
  logic eight, power_on;
  wire cb = mode == 2'h2;
  wire rd_low = !(io_read_strobe_n && mem_read_enable_n);
  wire wr_low = !(io_write_strobe_n && mem_write_enable_n);
  // Mirror control register fields.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode <= 2'h0;
      eight <= 1'h0;
      power_on <= 1'h0;
    end
    else if (psel && penable && pwrite && paddr == ADDR_CTRL)
    begin
      if (pwdata[1:0] != 2'h3)
        mode <= pwdata[1:0];
      eight <= pwdata[3];
      power_on <= pwdata[4] && pwdata[5];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wait_held;
    (!cb && (rd_low || wr_low) && !cycle_wait_n) [*4];
  endsequence
  sequence seated_s;
    (card_detect_n == 2'h0) [*6];
  endsequence
  one_strobe_a: assert property (!cb |-> !(rd_low && wr_low))
    else $error("both strobes low");
  read_dir_a: assert property (!cb && rd_low |-> !card_data_oe)
    else $error("data driven on read");
  write_dir_a: assert property (!cb && wr_low |-> card_data_oe)
    else $error("data not driven on write");
  enable_held_a: assert property (!cb && (rd_low || wr_low) |->
    !(card_enable_even_n && card_enable_odd_n))
    else $error("strobe without enable");
  eight_even_a: assert property (!cb && eight && (rd_low || wr_low)
    |-> card_enable_odd_n)
    else $error("odd enable on eight-bit card");
  wait_hold_a: assert property (wait_held |=> rd_low || wr_low)
    else $error("strobe ended under wait");
  detect_seated_a: assert property (seated_s |-> card_present)
    else $error("seated card not present");
  reset_float_a: assert property (
    (!(power_on && card_present)) [*2] |-> !card_reset_oe)
    else $error("card reset driven");
  cb_irq_a: assert property (
    cb && $past(cb) ##0 (!ready_or_irq) [*6] |-> card_irq)
    else $error("CardBus interrupt missed");
  cb_route_a: assert property (cb && $past(cb) |->
    io_read_strobe_n == $past(cb_pins.cad13) &&
    card_enable_even_n == $past(cb_pins.ccbe0_n))
    else $error("CardBus pins not routed");
endmodule // pcs_socket_asserts

bind pcs_socket pcs_socket_asserts u_asserts (.pclk, .presetn, .paddr,
  .psel, .penable, .pwrite, .pwdata, .io_read_strobe_n, .io_write_strobe_n,
  .mem_read_enable_n, .mem_write_enable_n, .card_enable_even_n,
  .card_enable_odd_n, .card_data_oe, .cycle_wait_n, .ready_or_irq,
  .card_detect_n, .card_present, .card_reset_oe, .card_irq, .cb_pins);

// >>> tb/pcs_socket_tb.sv
// Testbench of the socket block.
`timescale 1ns/1ps
module pcs_socket_tb;
  import pcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, a0_s;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic io_read_strobe_n, io_write_strobe_n, mem_read_enable_n;
  logic mem_write_enable_n, card_enable_even_n, card_enable_odd_n;
  logic card_a0, card_data_oe, protect_or_width, clkrun_out_n, clkrun_oe;
  logic cardbus_clk_run, ready_or_irq, cycle_wait_n, input_ack_n;
  logic battery_warn, battery_dead, card_reset_out, card_reset_oe;
  logic card_irq, card_speaker, activity_led, ring_wake, pme_n;
  logic card_present, seated, cardbus;
  logic [1:0] card_detect_n, voltage_sense;
  logic [15:0] card_data_in, card_data_out;
  logic [3:0] wait_len;
  logic [5:0] seen;
  pcs_cb_pins_t cb_pins;
  int err_count, compares, slen;
  wire strobe_n = io_read_strobe_n & io_write_strobe_n & mem_read_enable_n
    & mem_write_enable_n;

  pcs_socket #(.SETUP_COUNT(1), .STROBE_COUNT(4)) DUT (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .io_read_strobe_n, .io_write_strobe_n, .mem_read_enable_n,
    .mem_write_enable_n, .card_enable_even_n, .card_enable_odd_n, .card_a0,
    .card_data_in, .card_data_out, .card_data_oe, .protect_or_width,
    .clkrun_out_n, .clkrun_oe, .cardbus_clk_run, .ready_or_irq,
    .cycle_wait_n, .input_ack_n, .card_detect_n, .voltage_sense,
    .battery_warn, .battery_dead, .card_reset_out, .card_reset_oe, .cb_pins,
    .card_irq, .card_speaker, .activity_led, .ring_wake, .pme_n,
    .card_present);
  pcs_card_model card (.pclk, .strobe_n, .seated, .cardbus, .wait_len,
    .rd_word(16'hC3A5), .card_detect_n, .voltage_sense, .cycle_wait_n,
    .card_data_in);

  // Free-running clock of 8 ns.
  initial
  begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // Record the pins seen low under a strobe.
  always @(posedge pclk)
    if (!strobe_n)
    begin
      seen <= seen | ~{io_read_strobe_n, io_write_strobe_n,
        mem_read_enable_n, mem_write_enable_n, card_enable_even_n,
        card_enable_odd_n};
      a0_s <= card_a0;
      slen <= slen + 1;
    end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_count++;
    give_verdict;
  endtask
  // One APB transfer; data taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
      hang;
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'h0 && n < 200)
    begin
      apb(1'h0, ADDR_STATUS, 32'h0);
      n++;
    end
    if (n == 200)
      hang;
  endtask
  // Run one card cycle and check the pins seen.
  task automatic run(input logic [12:0] ctl, input logic [19:0] cmd,
    input logic pw, input logic [6:0] exp);
    apb(1'h1, ADDR_CTRL, {19'h0, ctl});
    protect_or_width <= pw;
    repeat (4) @(posedge pclk);
    seen = 6'h0;
    slen = 0;
    apb(1'h1, ADDR_CMD, {12'h0, cmd});
    wait_idle;
    chk({a0_s, seen}, exp);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    {psel, penable, pwrite, presetn, seated, cardbus, protect_or_width} = '0;
    {ready_or_irq, input_ack_n, battery_warn, battery_dead} = '1;
    {paddr, pwdata, wait_len, seen, cb_pins} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    chk({io_read_strobe_n, card_enable_odd_n, pme_n, card_reset_oe,
      card_data_oe}, 5'h1C);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk({slv, rd[30:0]}, 32'h8000_0000);
    $display("map test done");
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk({card_present, rd[3:1]}, 4'h0);
    seated <= 1'h1;
    repeat (6) @(posedge pclk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk({card_present, rd[3], rd[2] ^ rd[1]}, 3'h7);
    $display("detect test done");
    apb(1'h1, ADDR_CTRL, 32'h30);
    {protect_or_width, ready_or_irq, battery_warn, battery_dead} <= 4'h6;
    repeat (6) @(posedge pclk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk({rd[9:7], rd[5]}, 4'h5);
    {protect_or_width, ready_or_irq, battery_warn, battery_dead} <= 4'h3;
    repeat (6) @(posedge pclk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk({rd[9:7], rd[5]}, 4'hC);
    $display("memory test done");
    run(13'h30, 20'hA_1234, 1'h0, 7'h07);
    run(13'h30, 20'h1_0000, 1'h0, 7'h49);
    run(13'h38, 20'h1_0000, 1'h0, 7'h4A);
    run(13'h31, 20'hC_0000, 1'h0, 7'h23);
    apb(1'h0, ADDR_RDATA, 32'h0);
    chk(rd, 32'hC3A5);
    run(13'h31, 20'hE_5678, 1'h1, 7'h12);
    wait_len <= 4'h8;
    run(13'h30, 20'h0_0000, 1'h0, 7'h0A);
    chk(slen >= 8, 1);
    $display("cycle test done");
    wait_len <= 4'hF;
    apb(1'h1, ADDR_CMD, 32'hA_0000);
    apb(1'h1, ADDR_CTRL, 32'h31);
    wait_idle;
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h30);
    wait_len <= 4'h0;
    $display("lock test done");
    apb(1'h1, ADDR_CTRL, 32'h31);
    ready_or_irq <= 1'h0;
    repeat (6) @(posedge pclk);
    chk(card_irq, 1);
    ready_or_irq <= 1'h1;
    battery_dead <= 1'h0;
    repeat (6) @(posedge pclk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[10], 1);
    apb(1'h1, ADDR_STATUS, 32'h400);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(rd[10], 0);
    apb(1'h1, ADDR_CTRL, 32'h131);
    repeat (4) @(posedge pclk);
    chk(ring_wake, 1);
    $display("io test done");
    apb(1'h1, ADDR_CTRL, 32'h70);
    repeat (4) @(posedge pclk);
    chk({card_reset_oe, card_reset_out}, 2'h3);
    apb(1'h1, ADDR_CTRL, 32'h40);
    repeat (4) @(posedge pclk);
    chk(card_reset_oe, 0);
    $display("reset test done");
    cardbus <= 1'h1;
    cb_pins <= 6'h2A;
    apb(1'h1, ADDR_CTRL, 32'h1632);
    {ready_or_irq, battery_dead} <= 2'h1;
    repeat (6) @(posedge pclk);
    chk({io_read_strobe_n, io_write_strobe_n, mem_read_enable_n,
      mem_write_enable_n, card_enable_even_n, card_enable_odd_n},
      6'h29);
    chk({card_irq, pme_n}, 2'h2);
    apb(1'h1, ADDR_CMD, 32'hA_0000);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk({rd[3:1], rd[0]}, 4'hE);
    $display("cardbus test done");
    give_verdict;
  end
endmodule // pcs_socket_tb
